// ### rtl/pth_timer.sv
// Eight-bit period timer with prescaler, postscaler and hardware limit modes.
// Assumes software strobes and the external reset sources are synchronous
// to mclk; the selected external input obeys the trigger spacing limits.
// Function
// - Count advances on each prescaled tick whenever counting is enabled.
// - Count equal to period flags a match and clears on next tick.
// - Gate modes hold the count while the gate is inactive.
// - Reset clears count, sets period to all ones; both software writable.
// - Count write, control write, reset or external reset clear scalers.
// - Free-running match loads zero and bumps the postscaler.
// - Postscaler equal to select gives one-tick pulse and clears it.
// - One-shot clears run at match; restart needs run cycled.
// - One-shot stops count at zero, run cleared, on the match tick.
// - Monostable stops at zero, keeps run, restarts on external event.
// - Monostable keeps run set and restarts from an external event.
// - External input picked by source select; five-bit mode; reserved codes idle.
// - Debug freeze holds the external input level, so no edge trigger is seen.
// - Mode 0 gates on run; modes 1 and 2 also need input high/low.
// - Modes 3 to 5 reset the count on any, rising or falling edge.
// - Modes 6 and 7 hold the count in reset while input low/high.
// - One-shot 8 starts on run; 9 to 11 need a qualifying edge.
// - One-shot 12 to 15 start on edge; reset on edge or opposite level.
// - One-shot 22 and 23 start on level, reset at opposite level.
// - Edge-started modes need a fresh edge after run is set.
// - Prescaler ratio 1:1 to 1:128 ahead of the count.
// - Postscaled pulse raises a flag; enable gates it onto the interrupt.
`timescale 1ns/10ps
module pth_timer
    import pth_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_b,
    // Software access to count, period and control.
    input wire logic count_wr,
    input wire logic [7:0] count_wdata,
    input wire logic period_wr,
    input wire logic [7:0] period_wdata,
    input wire logic ctrl_wr,
    input wire pth_ctrl_s ctrl_wdata,
    input wire logic [4:0] limit_mode,
    input wire logic [4:0] ext_reset_source_select,
    // External reset sources and debug.
    input wire logic [31:0] ext_reset_sources,
    input wire logic debug_freeze,
    // Interrupt flag control.
    input wire logic period_irq_enable,
    input wire logic period_irq_clr,
    // Status and outputs.
    output logic [7:0] count_reg,
    output logic [7:0] period_reg,
    output logic run_enable_bit,
    output logic period_pulse_out,
    output logic period_irq_flag,
    output logic period_irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0] count_q;
    logic [7:0] period_q;
    pth_ctrl_s ctrl_q;
    logic [3:0] post_q;
    logic pulse_q;
    logic irq_q;
    logic ers_prev_q;
    pth_state_e st_q;
    pth_state_e st_d;
    pth_ext_s ext;
    logic ext_reset_input;
    logic ers_eff;
    logic prescaled_tick;
    logic match;
    logic gate_ok;
    logic cnt_en;
    logic step;
    logic ext_rst;
    logic start_ev;
    logic oneshot;
    logic sequenced;
    logic reserved;
    logic scaler_clr;
    logic post_hit;
    logic stop_now;

    // ****************************************************************
    // Mode decode
    // ****************************************************************

    // One-shot classes clear the run bit when they stop.
    function automatic logic is_oneshot(input logic [4:0] m);
        return (m[4:3] == 2'b01) || (m == PTH_O_HI_LR) || (m == PTH_O_LO_HR);
    endfunction : is_oneshot

    // Monostable class keeps the run bit when it stops.
    function automatic logic is_mono(input logic [4:0] m);
        return (m == PTH_S_RISE) || (m == PTH_S_FALL) || (m == PTH_S_ANY);
    endfunction : is_mono

    // Start event for the sequenced classes.
    function automatic logic start_of(input logic [4:0] m, input pth_ext_s e);
        logic r;
        r = 1'b0;
        case (m)
            PTH_O_SW: r = 1'b1;
            PTH_O_RISE, PTH_O_RISE_RR, PTH_O_RISE_LR, PTH_S_RISE: r = e.rise;
            PTH_O_FALL, PTH_O_FALL_FR, PTH_O_FALL_HR, PTH_S_FALL: r = e.fall;
            PTH_O_ANY, PTH_S_ANY: r = e.rise | e.fall;
            PTH_O_HI_LR: r = e.lvl;
            PTH_O_LO_HR: r = !e.lvl;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : start_of

    // External reset of the count: edge events and held levels.
    function automatic logic reset_of(input logic [4:0] m, input pth_ext_s e);
        logic r;
        r = 1'b0;
        case (m)
            PTH_M_RST_ANY: r = e.rise | e.fall;
            PTH_M_RST_RISE, PTH_O_RISE_RR: r = e.rise;
            PTH_M_RST_FALL, PTH_O_FALL_FR: r = e.fall;
            PTH_M_RST_LO, PTH_O_RISE_LR, PTH_O_HI_LR: r = !e.lvl;
            PTH_M_RST_HI, PTH_O_FALL_HR, PTH_O_LO_HR: r = e.lvl;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : reset_of

    // Source select, freeze hold and edge detection of the external input.
    assign ext_reset_input = ext_reset_sources[ext_reset_source_select];
    assign ers_eff = debug_freeze ? ers_prev_q : ext_reset_input;
    assign ext.lvl = ers_eff;
    assign ext.rise = ers_eff & !ers_prev_q;
    assign ext.fall = !ers_eff & ers_prev_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ers_prev_q <= 1'b0;
        end else begin
            ers_prev_q <= ers_eff;
        end
    end

    assign oneshot = is_oneshot(limit_mode);
    assign sequenced = oneshot | is_mono(limit_mode);
    assign reserved = (limit_mode[4:3] == 2'b11) || (limit_mode == 5'h10) ||
        (limit_mode == 5'h14) || (limit_mode == 5'h15);

    // Start only while run is set, so an edge seen with run clear is lost.
    assign start_ev = ctrl_q.run && start_of(limit_mode, ext);
    assign ext_rst = ctrl_q.run && reset_of(limit_mode, ext);

    // ****************************************************************
    // Gating and counting
    // ****************************************************************

    // Free-running gate, sequenced state, and the reserved codes stopping.
    always_comb begin
        case (limit_mode)
            PTH_M_GATE_HI: gate_ok = ext.lvl;
            PTH_M_GATE_LO: gate_ok = !ext.lvl;
            default: gate_ok = 1'b1;
        endcase
    end

    assign cnt_en = ctrl_q.run && gate_ok && !reserved && !ext_rst &&
        (!sequenced || (st_q == PTH_ST_COUNT));
    assign match = (count_q == period_q);
    assign step = prescaled_tick && cnt_en;
    assign stop_now = step && match && sequenced;
    assign post_hit = step && match && (post_q == ctrl_q.postscale_select);
    assign scaler_clr = count_wr || ctrl_wr || ext_rst;

    // Prescaler ahead of the count register.
    pth_prescaler u_pre (
        .mclk(mclk),
        .rst_b(rst_b),
        .clr(scaler_clr),
        .ckps(ctrl_q.ckps),
        .prescaled_tick(prescaled_tick),
        .pre_cnt()
    );

    // Count register: software write, external reset, then tick.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= PTH_COUNT_RST;
        end else if (count_wr) begin
            count_q <= count_wdata;
        end else if (ext_rst) begin
            count_q <= PTH_COUNT_RST;
        end else if (step && match) begin
            count_q <= PTH_COUNT_RST;
        end else if (step) begin
            count_q <= count_q + 8'h01;
        end
    end

    // Period register, all ones after reset.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            period_q <= PTH_PERIOD_RST;
        end else if (period_wr) begin
            period_q <= period_wdata;
        end
    end

    // Control word; one-shot stop clears run unless software writes now.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= PTH_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_q <= ctrl_wdata;
        end else if (stop_now && oneshot) begin
            ctrl_q.run <= 1'b0;
        end
    end

    // ****************************************************************
    // Start and stop sequencer
    // ****************************************************************

    // Idle waits for a start, done waits for a restart or run off.
    always_comb begin
        st_d = st_q;
        case (st_q)
            PTH_ST_IDLE: begin
                if (start_ev) begin
                    st_d = PTH_ST_COUNT;
                end
            end
            PTH_ST_COUNT: begin
                if (stop_now) begin
                    st_d = PTH_ST_DONE;
                end
            end
            PTH_ST_DONE: begin
                if (start_ev && !oneshot) begin
                    st_d = PTH_ST_COUNT;
                end
            end
            default: st_d = PTH_ST_IDLE;
        endcase
        if (!ctrl_q.run || ctrl_wr || !sequenced) begin
            st_d = PTH_ST_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= PTH_ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Postscaler, period pulse and interrupt flag
    // ****************************************************************

    // Postscaler counts period matches and wraps at the select value.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            post_q <= PTH_POST_RST;
        end else if (scaler_clr || post_hit) begin
            post_q <= PTH_POST_RST;
        end else if (step && match) begin
            post_q <= post_q + 4'h1;
        end
    end

    // Pulse lasts from the matching tick to the next tick.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_q <= 1'b0;
        end else if (post_hit) begin
            pulse_q <= 1'b1;
        end else if (prescaled_tick || scaler_clr) begin
            pulse_q <= 1'b0;
        end
    end

    // Sticky flag; a new pulse wins over a clear in the same cycle.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else if (post_hit) begin
            irq_q <= 1'b1;
        end else if (period_irq_clr) begin
            irq_q <= 1'b0;
        end
    end

    assign count_reg = count_q;
    assign period_reg = period_q;
    assign run_enable_bit = ctrl_q.run;
    assign period_pulse_out = pulse_q;
    assign period_irq_flag = irq_q;
    assign period_irq = irq_q && period_irq_enable;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_count_step_up: assert property (
        step && !match && !count_wr |=> count_q == $past(count_q) + 8'h01)
        else $error("count did not advance on tick");

    a_match_to_zero: assert property (
        step && match && !count_wr |=> count_q == 8'h00)
        else $error("count not cleared after period match");

    a_gate_holds: assert property (
        !cnt_en && !count_wr && !ext_rst ##1 !count_wr
        |-> count_q == $past(count_q))
        else $error("count moved while gated");

    a_scaler_cleared: assert property (
        count_wr || ctrl_wr |=> post_q == 4'h0 && u_pre.pre_q == 7'h00)
        else $error("scalers not cleared by write");

    a_pulse_wrap: assert property (
        post_hit |=> pulse_q && post_q == 4'h0 && irq_q)
        else $error("postscaler pulse missing");

    a_oneshot_stop: assert property (
        stop_now && oneshot && !ctrl_wr && !count_wr
        |=> !ctrl_q.run && count_q == 8'h00 ##1 st_q == PTH_ST_IDLE)
        else $error("one-shot did not stop");

    a_mono_keeps_run: assert property (
        stop_now && !oneshot && !ctrl_wr
        |=> ctrl_q.run && st_q == PTH_ST_DONE)
        else $error("monostable lost run bit");

    a_freeze_ignored: assert property (
        debug_freeze |-> !ext.rise && !ext.fall)
        else $error("edge seen during freeze");

    a_level_reset: assert property (
        ext_rst && !count_wr |=> count_q == 8'h00 && post_q == 4'h0)
        else $error("external reset did not clear count");

    a_reserved_idle: assert property (
        reserved && !count_wr |=> count_q == $past(count_q))
        else $error("reserved mode counted");

endmodule : pth_timer

// ### rtl/pth_pkg.sv
// Shared constants, mode codes, state and control types for the period timer.
// Assumes a single clock domain; the count and postscaler advance on the prescaled tick.
package pth_pkg;

    // Widths and reset values of the count, period, postscaler and prescaler registers.
    localparam int PTH_CW = 8;
    localparam int PTH_PW = 7;
    localparam logic [7:0] PTH_COUNT_RST = 8'h00;
    localparam logic [7:0] PTH_PERIOD_RST = 8'hff;
    localparam logic [3:0] PTH_POST_RST = 4'h0;
    localparam logic [6:0] PTH_PRE_RST = 7'h00;

    // Hardware-limit mode codes, free-running class.
    localparam logic [4:0] PTH_M_SWGATE = 5'h00;
    localparam logic [4:0] PTH_M_GATE_HI = 5'h01;
    localparam logic [4:0] PTH_M_GATE_LO = 5'h02;
    localparam logic [4:0] PTH_M_RST_ANY = 5'h03;
    localparam logic [4:0] PTH_M_RST_RISE = 5'h04;
    localparam logic [4:0] PTH_M_RST_FALL = 5'h05;
    localparam logic [4:0] PTH_M_RST_LO = 5'h06;
    localparam logic [4:0] PTH_M_RST_HI = 5'h07;
    // One-shot class.
    localparam logic [4:0] PTH_O_SW = 5'h08;
    localparam logic [4:0] PTH_O_RISE = 5'h09;
    localparam logic [4:0] PTH_O_FALL = 5'h0a;
    localparam logic [4:0] PTH_O_ANY = 5'h0b;
    localparam logic [4:0] PTH_O_RISE_RR = 5'h0c;
    localparam logic [4:0] PTH_O_FALL_FR = 5'h0d;
    localparam logic [4:0] PTH_O_RISE_LR = 5'h0e;
    localparam logic [4:0] PTH_O_FALL_HR = 5'h0f;
    // Monostable class.
    localparam logic [4:0] PTH_S_RISE = 5'h11;
    localparam logic [4:0] PTH_S_FALL = 5'h12;
    localparam logic [4:0] PTH_S_ANY = 5'h13;
    // Level-started one-shot class.
    localparam logic [4:0] PTH_O_HI_LR = 5'h16;
    localparam logic [4:0] PTH_O_LO_HR = 5'h17;

    // Start and stop sequencer for the one-shot and monostable classes.
    typedef enum logic [2:0] {
        PTH_ST_IDLE = 3'b001,
        PTH_ST_COUNT = 3'b010,
        PTH_ST_DONE = 3'b100
    } pth_state_e;

    // Timer control word: run bit, prescale code, postscale select.
    typedef struct packed {
        logic run;
        logic [2:0] ckps;
        logic [3:0] postscale_select;
    } pth_ctrl_s;

    localparam pth_ctrl_s PTH_CTRL_RST = 8'h00;

    // Edge and level view of the external reset input.
    typedef struct packed {
        logic lvl;
        logic rise;
        logic fall;
    } pth_ext_s;

    // Mask of prescaler bits that must be all ones for a tick.
    function automatic logic [6:0] pth_pre_mask(input logic [2:0] ckps);
        logic [7:0] m;
        m = (8'h01 << ckps) - 8'h01;
        return m[6:0];
    endfunction : pth_pre_mask

endpackage : pth_pkg

// ### rtl/pth_prescaler.sv
// Programmable prescaler giving one tick every 1, 2, 4 ... 128 clocks.
// Assumes clr is a synchronous request from the timer core; a level reset holds it high for many cycles.
`timescale 1ns/10ps
module pth_prescaler
    import pth_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_b,
    // Control.
    input wire logic clr,
    input wire logic [2:0] ckps,
    // Tick out and counter view.
    output logic prescaled_tick,
    output logic [6:0] pre_cnt
);

    logic [6:0] pre_q;
    logic [6:0] pre_d;

    // Free-running divider, restarted by clr.
    always_comb begin
        pre_d = clr ? PTH_PRE_RST : pre_q + 7'h01;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= PTH_PRE_RST;
        end else begin
            pre_q <= pre_d;
        end
    end

    // Tick when the selected low bits are all ones; code 0 ticks every clock.
    assign prescaled_tick = !clr &&
        ((pre_q & pth_pre_mask(ckps)) == pth_pre_mask(ckps));
    assign pre_cnt = pre_q;

endmodule : pth_prescaler

// ### tb/pth_ext_model.sv
// Model of the on-chip logic that drives the timer's external reset input.
// Assumes it is clocked by the timer clock with a 1:1 prescale.
`timescale 1ns/10ps
// ****************************************************************
// External reset driver
// ****************************************************************
module pth_ext_model (
    // Clock.
    input wire logic mclk,
    // Driven external level.
    output logic ext_line
);
    // The line is low until the first request.
    initial begin
        ext_line = 1'b0;
    end

    // Moves the line just after a falling edge, after a settling gap.
    task automatic drive(input logic v);
        repeat (8) @(negedge mclk);
        ext_line = v;
    endtask : drive
endmodule : pth_ext_model

// ### tb/tb_top.sv
// Self-checking bench for the period timer.
// Assumes the partner model drives the selected bit of the external sources.
`timescale 1ns/10ps
// ****************************************************************
// Bench top
// ****************************************************************
module tb_top;
    import pth_pkg::*;
    logic mclk, rst_b, count_wr, period_wr, ctrl_wr, debug_freeze;
    logic period_irq_enable, period_irq_clr, ext_line;
    logic [7:0] count_wdata, period_wdata, count_reg, period_reg, snap;
    logic [4:0] limit_mode, src_sel;
    logic [31:0] srcs;
    pth_ctrl_s ctrl_wdata;
    logic run_enable_bit, period_pulse_out, period_irq_flag, period_irq;
    logic [7:0] hits;
    int n_fail, checks;

    // Unselected sources carry the inverse so a wrong pick shows.
    always_comb begin
        srcs = {32{~ext_line}};
        srcs[src_sel] = ext_line;
    end

    pth_ext_model i_ext (.mclk(mclk), .ext_line(ext_line));

    pth_timer i_dut (.mclk(mclk), .rst_b(rst_b), .count_wr(count_wr),
        .count_wdata(count_wdata), .period_wr(period_wr),
        .period_wdata(period_wdata), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .limit_mode(limit_mode),
        .ext_reset_source_select(src_sel), .ext_reset_sources(srcs),
        .debug_freeze(debug_freeze), .period_irq_enable(period_irq_enable),
        .period_irq_clr(period_irq_clr), .count_reg(count_reg),
        .period_reg(period_reg), .run_enable_bit(run_enable_bit),
        .period_pulse_out(period_pulse_out),
        .period_irq_flag(period_irq_flag), .period_irq(period_irq));

    // The clock runs at 10 MHz.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Compares one value and counts the outcome.
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // Software strobes are one clock wide, set and cleared at negedges.
    task automatic wr_count(input logic [7:0] d);
        count_wdata = d;
        count_wr = 1'b1;
        @(negedge mclk);
        count_wr = 1'b0;
    endtask : wr_count

    task automatic wr_period(input logic [7:0] d);
        period_wdata = d;
        period_wr = 1'b1;
        @(negedge mclk);
        period_wr = 1'b0;
    endtask : wr_period

    task automatic wr_ctrl(input logic r, input logic [2:0] ps,
                           input logic [3:0] os);
        ctrl_wdata = {r, ps, os};
        ctrl_wr = 1'b1;
        @(negedge mclk);
        ctrl_wr = 1'b0;
    endtask : wr_ctrl

    // Counts rising edges of the period pulse over n clocks.
    task automatic count_rises(input int n);
        logic prev;
        prev = period_pulse_out;
        hits = 8'h00;
        repeat (n) begin
            @(negedge mclk);
            if (period_pulse_out === 1'b1 && prev === 1'b0) hits++;
            prev = period_pulse_out;
        end
    endtask : count_rises

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #3000000;
        n_fail++;
        end_of_test();
    end

    // Main sequence of scenarios.
    initial begin
        rst_b = 1'b0;
        {count_wr, period_wr, ctrl_wr, debug_freeze} = 4'h0;
        {period_irq_enable, period_irq_clr} = 2'b00;
        count_wdata = 8'h00;
        period_wdata = 8'h00;
        ctrl_wdata = PTH_CTRL_RST;
        limit_mode = PTH_M_SWGATE;
        src_sel = 5'h05;
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        check("count_rst", count_reg, 8'h00);
        check("period_rst", period_reg, 8'hff);
        check("run_rst", {7'h00, run_enable_bit}, 8'h00);
        // Software gate walk with period one.
        wr_period(8'h01);
        wr_ctrl(1'b1, 3'h0, 4'h0);
        check("walk_c0", count_reg, 8'h00);
        @(negedge mclk);
        check("walk_c1", count_reg, 8'h01);
        @(negedge mclk);
        check("walk_c2", count_reg, 8'h00);
        check("walk_pulse", {7'h00, period_pulse_out}, 8'h01);
        check("walk_flag", {7'h00, period_irq_flag}, 8'h01);
        check("walk_irq_off", {7'h00, period_irq}, 8'h00);
        @(negedge mclk);
        check("walk_c3", count_reg, 8'h01);
        check("walk_pulse0", {7'h00, period_pulse_out}, 8'h00);
        period_irq_enable = 1'b1;
        @(negedge mclk);
        check("irq_on", {7'h00, period_irq}, 8'h01);
        // Postscale 1:3 gives one pulse every six clocks.
        wr_ctrl(1'b1, 3'h0, 4'h2);
        count_rises(60);
        check("postscale", hits, 8'h0a);
        // Every prescale ratio, two ticks per period.
        for (int k = 0; k < 8; k++) begin
            wr_ctrl(1'b1, 3'(k), 4'h0);
            count_rises(256);
            check("prescale", hits, 8'(128 >> k));
        end
        wr_ctrl(1'b0, 3'h0, 4'h0);
        period_irq_clr = 1'b1;
        @(negedge mclk);
        period_irq_clr = 1'b0;
        check("flag_clr", {7'h00, period_irq_flag}, 8'h00);
        // Register access and control write keeping the count.
        wr_count(8'h37);
        check("count_wr", count_reg, 8'h37);
        wr_period(8'h5a);
        check("period_wr", period_reg, 8'h5a);
        wr_ctrl(1'b0, 3'h1, 4'h0);
        check("ctrl_keep", count_reg, 8'h37);
        // One-shot with software start, postscale zero.
        limit_mode = PTH_O_SW;
        wr_period(8'h03);
        wr_count(8'h00);
        wr_ctrl(1'b1, 3'h0, 4'h0);
        repeat (10) @(negedge mclk);
        check("os_run", {7'h00, run_enable_bit}, 8'h00);
        check("os_count", count_reg, 8'h00);
        wr_ctrl(1'b1, 3'h0, 4'h0);
        repeat (3) @(negedge mclk);
        check("os_again", {7'h00, count_reg != 8'h00}, 8'h01);
        // Hardware gate, active high.
        limit_mode = PTH_M_GATE_HI;
        wr_period(8'hff);
        wr_count(8'h00);
        wr_ctrl(1'b1, 3'h0, 4'h0);
        repeat (5) @(negedge mclk);
        check("gate_closed", count_reg, 8'h00);
        i_ext.drive(1'b1);
        repeat (5) @(negedge mclk);
        check("gate_open", {7'h00, count_reg != 8'h00}, 8'h01);
        i_ext.drive(1'b0);
        repeat (2) @(negedge mclk);
        snap = count_reg;
        repeat (5) @(negedge mclk);
        check("gate_hold", count_reg, snap);
        // Rising edge reset, then the same edge under debug freeze.
        limit_mode = PTH_M_RST_RISE;
        wr_count(8'h00);
        wr_ctrl(1'b1, 3'h0, 4'h0);
        repeat (20) @(negedge mclk);
        i_ext.drive(1'b1);
        repeat (2) @(negedge mclk);
        check("edge_rst", {7'h00, count_reg < 8'h03}, 8'h01);
        debug_freeze = 1'b1;
        i_ext.drive(1'b0);
        i_ext.drive(1'b1);
        repeat (2) @(negedge mclk);
        check("freeze", {7'h00, count_reg > 8'h0a}, 8'h01);
        debug_freeze = 1'b0;
        // High level holds the count in reset.
        limit_mode = PTH_M_RST_HI;
        repeat (5) @(negedge mclk);
        check("lvl_rst", count_reg, 8'h00);
        // Reserved code holds the count.
        i_ext.drive(1'b0);
        limit_mode = 5'h10;
        wr_count(8'h05);
        wr_ctrl(1'b1, 3'h0, 4'h0);
        repeat (10) @(negedge mclk);
        check("reserved", count_reg, 8'h05);
        // Monostable, rising edge start.
        limit_mode = PTH_S_RISE;
        wr_period(8'h03);
        wr_count(8'h00);
        wr_ctrl(1'b1, 3'h0, 4'h0);
        repeat (5) @(negedge mclk);
        check("mono_wait", count_reg, 8'h00);
        i_ext.drive(1'b1);
        repeat (12) @(negedge mclk);
        check("mono_stop", count_reg, 8'h00);
        check("mono_run", {7'h00, run_enable_bit}, 8'h01);
        i_ext.drive(1'b0);
        i_ext.drive(1'b1);
        repeat (3) @(negedge mclk);
        check("mono_again", {7'h00, count_reg != 8'h00}, 8'h01);
        // Edge start with edge reset on another source; run-off edge lost.
        wr_ctrl(1'b0, 3'h0, 4'h0);
        limit_mode = PTH_O_RISE_RR;
        src_sel = 5'h1c;
        wr_period(8'h20);
        i_ext.drive(1'b0);
        i_ext.drive(1'b1);
        wr_count(8'h00);
        wr_ctrl(1'b1, 3'h0, 4'h0);
        repeat (5) @(negedge mclk);
        check("os_edge_wait", count_reg, 8'h00);
        i_ext.drive(1'b0);
        i_ext.drive(1'b1);
        repeat (3) @(negedge mclk);
        check("os_rr_start", count_reg, 8'h02);
        i_ext.drive(1'b0);
        i_ext.drive(1'b1);
        repeat (2) @(negedge mclk);
        check("os_rr_reset", count_reg, 8'h01);
        repeat (40) @(negedge mclk);
        check("os_rr_run", {7'h00, run_enable_bit}, 8'h00);
        check("os_rr_count", count_reg, 8'h00);
        // Level-started one-shot: high starts, low holds in reset.
        limit_mode = PTH_O_HI_LR;
        wr_period(8'h40);
        wr_ctrl(1'b1, 3'h0, 4'h0);
        repeat (4) @(negedge mclk);
        check("os_lvl_start", count_reg, 8'h03);
        i_ext.drive(1'b0);
        repeat (3) @(negedge mclk);
        check("os_lvl_reset", count_reg, 8'h00);
        end_of_test();
    end
endmodule : tb_top
